// ---- logic/lss_pkg.sv ----
package lss_pkg;
	// Register map, byte offsets on the 8-bit address port
	localparam logic [7:0] ADDR_SYS_CONFIG = 8'h01;
	localparam logic [7:0] ADDR_MODE = 8'h12;
	localparam logic [7:0] ADDR_SCROLL_CTRL = 8'h13;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_WINDOW_WIDTH = 8'h21;
	localparam logic [7:0] ADDR_WINDOW_HEIGHT = 8'h31;
	localparam logic [7:0] ADDR_CURSOR_ROW = 8'h70;
	localparam logic [7:0] ADDR_SCROLL_TOP_ROW = 8'h71;
	localparam logic [7:0] ADDR_SCROLL_BOTTOM_ROW = 8'h72;
	localparam logic [7:0] ADDR_BLINK_SCROLL_PERIOD = 8'h80;
	localparam logic [7:0] ADDR_ROW_IDLE_COUNT = 8'h90;

	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [5:0] RST_WINDOW_WIDTH = 6'h27;
	localparam logic [7:0] RST_WINDOW_HEIGHT = 8'hEF;

	// Field positions and values
	localparam int DIV_LSB = 2;
	localparam int DIV_MSB = 3;
	localparam int TARGET_LSB = 0;
	localparam int TARGET_MSB = 1;
	localparam int MODE_LSB = 4;
	localparam int MODE_MSB = 6;
	localparam logic [1:0] TARGET_FONT_RAM = 2'h0;
	localparam logic [2:0] MODE_EXT1 = 3'h7;
	localparam logic [2:0] MODE_EXT2 = 3'h6;
	localparam logic [7:0] ROW_MAX = 8'hEF;
	localparam int GLYPH_MSB = 3;

	// Shift clock divisor is DIV_BASE >> field: 00 -> 8, 11 -> 1
	localparam logic [3:0] DIV_BASE = 4'h8;

	// Driver bus widths, expressed as shift of the column count
	localparam logic [1:0] BUS4_SHIFT = 2'h1;
	localparam logic [1:0] BUS8_SHIFT = 2'h0;
	localparam logic [3:0] COLUMNS_PER_UNIT = 4'h8;
endpackage

// ---- logic/lss_scan_timing.sv ----
module lss_scan_timing (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// Panel strap, asynchronous
	input wire logic i_driver_width_pin,
	// Panel timing
	output logic o_shift_clock,
	output logic o_row_start,
	output logic [7:0] o_row_line,
	output logic o_frame_start,
	// Cursor and scroll
	output logic o_blink_phase,
	output logic o_scroll_step,
	output logic [7:0] o_scroll_row,
	output logic [3:0] o_ram_addr_hi,
	output logic [3:0] o_font_glyph,
	output logic o_font_select
);

	function automatic logic [3:0] shift_divisor(input logic [7:0] cfg);
		shift_divisor = lss_pkg::DIV_BASE >> cfg[lss_pkg::DIV_MSB:lss_pkg::DIV_LSB];
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
		hit = (a == reg_addr);
	endfunction

	// Register file
	logic [7:0] sys_config;
	logic [7:0] mode;
	logic scroll_enable;
	logic [5:0] window_width;
	logic [7:0] window_height;
	logic [7:0] cursor_row;
	logic [7:0] scroll_top_row;
	logic [7:0] scroll_bottom_row;
	logic [7:0] blink_scroll_period;
	logic [7:0] row_idle_count;
	logic [7:0] next_sys_config;
	logic [7:0] next_mode;
	logic next_scroll_enable;
	logic [5:0] next_window_width;
	logic [7:0] next_window_height;
	logic [7:0] next_cursor_row;
	logic [7:0] next_scroll_top_row;
	logic [7:0] next_scroll_bottom_row;
	logic [7:0] next_blink_scroll_period;
	logic [7:0] next_row_idle_count;
	logic [7:0] next_rdata;

	// Pin synchroniser
	logic dw_meta;
	logic dw_sync;

	// Scan timing state
	logic [3:0] div_cnt;
	logic [9:0] col_cnt;
	logic [7:0] row_cnt;
	logic [7:0] frame_cnt;
	logic [3:0] next_div_cnt;
	logic [9:0] next_col_cnt;
	logic [7:0] next_row_cnt;
	logic [7:0] next_frame_cnt;
	logic next_shift_clock;
	logic next_row_start;
	logic next_frame_start;
	logic next_blink_phase;
	logic next_scroll_step;
	logic [7:0] next_scroll_row;

	// Timing terms
	logic [3:0] divisor;
	logic shift_tick;
	logic extension_flag;
	logic [1:0] bus_shift;
	logic [9:0] row_shift_cycles;
	logic [9:0] row_period;
	logic row_end;
	logic frame_end;
	logic [7:0] blink_limit;

	always_comb
	begin
		next_sys_config = sys_config;
		next_mode = mode;
		next_scroll_enable = scroll_enable;
		next_window_width = window_width;
		next_window_height = window_height;
		next_cursor_row = cursor_row;
		next_scroll_top_row = scroll_top_row;
		next_scroll_bottom_row = scroll_bottom_row;
		next_blink_scroll_period = blink_scroll_period;
		next_row_idle_count = row_idle_count;
		next_rdata = lss_pkg::RST_ZERO;
		if (i_wr)
		begin
			if (hit(i_addr, lss_pkg::ADDR_SYS_CONFIG))
				next_sys_config = i_wdata;
			if (hit(i_addr, lss_pkg::ADDR_MODE))
				next_mode = i_wdata;
			if (hit(i_addr, lss_pkg::ADDR_SCROLL_CTRL))
				next_scroll_enable = i_wdata[0];
			if (hit(i_addr, lss_pkg::ADDR_WINDOW_WIDTH))
				next_window_width = i_wdata[5:0];
			if (hit(i_addr, lss_pkg::ADDR_WINDOW_HEIGHT))
				next_window_height = i_wdata;
			// Out of range cursor rows saturate rather than wrap into RAM beyond the panel
			if (hit(i_addr, lss_pkg::ADDR_CURSOR_ROW))
				next_cursor_row = (i_wdata > lss_pkg::ROW_MAX) ? lss_pkg::ROW_MAX : i_wdata;
			if (hit(i_addr, lss_pkg::ADDR_SCROLL_TOP_ROW))
				next_scroll_top_row = i_wdata;
			if (hit(i_addr, lss_pkg::ADDR_SCROLL_BOTTOM_ROW))
				next_scroll_bottom_row = i_wdata;
			if (hit(i_addr, lss_pkg::ADDR_BLINK_SCROLL_PERIOD))
				next_blink_scroll_period = i_wdata;
			if (hit(i_addr, lss_pkg::ADDR_ROW_IDLE_COUNT))
				next_row_idle_count = i_wdata;
		end
		if (i_rd)
		begin
			case (i_addr)
				lss_pkg::ADDR_SYS_CONFIG: next_rdata = sys_config;
				lss_pkg::ADDR_MODE: next_rdata = mode;
				lss_pkg::ADDR_SCROLL_CTRL: next_rdata = {7'h00, scroll_enable};
				lss_pkg::ADDR_STATUS: next_rdata = {6'h00, dw_sync, o_blink_phase};
				lss_pkg::ADDR_WINDOW_WIDTH: next_rdata = {2'h0, window_width};
				lss_pkg::ADDR_WINDOW_HEIGHT: next_rdata = window_height;
				lss_pkg::ADDR_CURSOR_ROW: next_rdata = cursor_row;
				lss_pkg::ADDR_SCROLL_TOP_ROW: next_rdata = scroll_top_row;
				lss_pkg::ADDR_SCROLL_BOTTOM_ROW: next_rdata = scroll_bottom_row;
				lss_pkg::ADDR_BLINK_SCROLL_PERIOD: next_rdata = blink_scroll_period;
				lss_pkg::ADDR_ROW_IDLE_COUNT: next_rdata = row_idle_count;
				default: next_rdata = lss_pkg::RST_ZERO;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			sys_config <= lss_pkg::RST_ZERO;
			mode <= lss_pkg::RST_ZERO;
			scroll_enable <= 1'b0;
			window_width <= lss_pkg::RST_WINDOW_WIDTH;
			window_height <= lss_pkg::RST_WINDOW_HEIGHT;
			cursor_row <= lss_pkg::RST_ZERO;
			scroll_top_row <= lss_pkg::RST_ZERO;
			scroll_bottom_row <= lss_pkg::RST_ZERO;
			blink_scroll_period <= lss_pkg::RST_ZERO;
			row_idle_count <= lss_pkg::RST_ZERO;
			o_rdata <= lss_pkg::RST_ZERO;
		end
		else
		begin
			sys_config <= next_sys_config;
			mode <= next_mode;
			scroll_enable <= next_scroll_enable;
			window_width <= next_window_width;
			window_height <= next_window_height;
			cursor_row <= next_cursor_row;
			scroll_top_row <= next_scroll_top_row;
			scroll_bottom_row <= next_scroll_bottom_row;
			blink_scroll_period <= next_blink_scroll_period;
			row_idle_count <= next_row_idle_count;
			o_rdata <= next_rdata;
		end
	end

	// Strap may change at any time; only dw_sync is read
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			dw_meta <= 1'b0;
			dw_sync <= 1'b0;
		end
		else
		begin
			dw_meta <= i_driver_width_pin;
			dw_sync <= dw_meta;
		end
	end

	always_comb
	begin
		divisor = shift_divisor(sys_config);
		// Terminal compares use >= so a shortened setting ends the count at once
		shift_tick = (div_cnt >= divisor - 4'h1);
		extension_flag = (mode[lss_pkg::MODE_MSB:lss_pkg::MODE_LSB] == lss_pkg::MODE_EXT1)
			|| (mode[lss_pkg::MODE_MSB:lss_pkg::MODE_LSB] == lss_pkg::MODE_EXT2);
		bus_shift = dw_sync ? lss_pkg::BUS8_SHIFT : lss_pkg::BUS4_SHIFT;
		// Column count is units of eight, so dividing by 4 or 8 is a shift
		row_shift_cycles = ({4'h0, window_width} + 10'h001)
			* {6'h00, lss_pkg::COLUMNS_PER_UNIT} / 10'h008;
		row_shift_cycles = row_shift_cycles << (bus_shift + {1'b0, extension_flag});
		row_period = row_shift_cycles + {2'h0, row_idle_count};
		row_end = shift_tick && (col_cnt >= row_period - 10'h001);
		frame_end = row_end && (row_cnt >= window_height);
		blink_limit = (blink_scroll_period == lss_pkg::RST_ZERO) ? 8'h01
			: blink_scroll_period;

		next_div_cnt = shift_tick ? 4'h0 : div_cnt + 4'h1;
		// Divide by one cannot toggle from a flop; shift clock then idles low
		next_shift_clock = (next_div_cnt < (divisor >> 1));
		next_col_cnt = row_end ? 10'h000 : (shift_tick ? col_cnt + 10'h001 : col_cnt);
		next_row_cnt = frame_end ? 8'h00 : (row_end ? row_cnt + 8'h01 : row_cnt);
		next_row_start = row_end;
		next_frame_start = frame_end;

		next_frame_cnt = frame_cnt;
		next_blink_phase = o_blink_phase;
		next_scroll_step = 1'b0;
		next_scroll_row = o_scroll_row;
		if (frame_end)
		begin
			if (frame_cnt + 8'h01 >= blink_limit)
			begin
				next_frame_cnt = 8'h00;
				next_blink_phase = ~o_blink_phase;
				next_scroll_step = scroll_enable;
				// Bounds are trusted as loaded; outside the window restarts at top
				if (scroll_enable)
				begin
					if (o_scroll_row >= scroll_bottom_row || o_scroll_row < scroll_top_row)
						next_scroll_row = scroll_top_row;
					else
						next_scroll_row = o_scroll_row + 8'h01;
				end
			end
			else
				next_frame_cnt = frame_cnt + 8'h01;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			div_cnt <= 4'h0;
			col_cnt <= 10'h000;
			row_cnt <= 8'h00;
			frame_cnt <= 8'h00;
			o_shift_clock <= 1'b0;
			o_row_start <= 1'b0;
			o_row_line <= 8'h00;
			o_frame_start <= 1'b0;
			o_blink_phase <= 1'b0;
			o_scroll_step <= 1'b0;
			o_scroll_row <= 8'h00;
		end
		else
		begin
			div_cnt <= next_div_cnt;
			col_cnt <= next_col_cnt;
			row_cnt <= next_row_cnt;
			frame_cnt <= next_frame_cnt;
			o_shift_clock <= next_shift_clock;
			o_row_start <= next_row_start;
			o_row_line <= next_row_cnt;
			o_frame_start <= next_frame_start;
			o_blink_phase <= next_blink_phase;
			o_scroll_step <= next_scroll_step;
			o_scroll_row <= next_scroll_row;
		end
	end

	// Address and glyph outputs load from the next register values, on the same edge as the registers
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_ram_addr_hi <= 4'h0;
			o_font_glyph <= 4'h0;
			o_font_select <= 1'b0;
		end
		else
		begin
			o_ram_addr_hi <= next_cursor_row[3:0];
			o_font_glyph <= next_cursor_row[lss_pkg::GLYPH_MSB:0];
			o_font_select <= (next_mode[lss_pkg::TARGET_MSB:lss_pkg::TARGET_LSB]
				== lss_pkg::TARGET_FONT_RAM);
		end
	end

endmodule

// ---- test/lss_scan_timing_chk.sv ----
module lss_scan_timing_chk (
	// Watched ports
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_row_start,
	input wire logic o_frame_start,
	input wire logic o_blink_phase,
	input wire logic o_scroll_step,
	input wire logic [3:0] o_ram_addr_hi,
	input wire logic [3:0] o_font_glyph,
	input wire logic [7:0] o_row_line,
	input wire logic o_font_select
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside read slot");
	cursor_read_a: assert property (i_rd && i_addr == 8'h70 |=> o_rdata <= 8'hEF)
		else $error("cursor row above last row");
	cursor_sat_a: assert property (i_wr && i_addr == 8'h70 && i_wdata > 8'hEF
		|=> o_ram_addr_hi == 4'hF)
		else $error("cursor row not saturated");
	ram_hi_a: assert property (i_wr && i_addr == 8'h70 && i_wdata <= 8'hEF
		|=> o_ram_addr_hi == $past(i_wdata[3:0]))
		else $error("ram address bits wrong");
	glyph_sel_a: assert property (i_wr && i_addr == 8'h70 && i_wdata <= 8'hEF
		|=> o_font_glyph == $past(i_wdata[3:0]))
		else $error("font glyph select wrong");
	font_sel_a: assert property (i_wr && i_addr == 8'h12
		|=> o_font_select == (($past(i_wdata) & 8'h03) == 8'h00))
		else $error("font target select wrong");
	frame_row_a: assert property (o_frame_start |-> o_row_start)
		else $error("frame pulse without row pulse");
	row_wrap_a: assert property (o_frame_start |-> o_row_line == 8'h00)
		else $error("frame pulse off row zero");
	step_blink_a: assert property (o_scroll_step |-> o_blink_phase != $past(o_blink_phase))
		else $error("scroll step off blink toggle");
	blink_frame_a: assert property ($changed(o_blink_phase)
		|-> o_frame_start || $past(o_frame_start) || $past(o_frame_start, 2))
		else $error("blink toggled away from frame");
endmodule

// ---- test/lss_panel_model.sv ----
module lss_panel_model (
	// Panel lines
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_sck,
	input wire logic i_row,
	input wire logic i_frm,
	// Measured counts
	output logic [15:0] o_ticks,
	output logic [15:0] o_rows
);
	timeunit 1ns;
	timeprecision 1ps;
	logic d;
	logic [15:0] t, r, u;
	// Rise seen at the edge, as the driver chip would latch it
	assign u = {15'h0000, i_sck & ~d};
	always_ff @(posedge i_ref_clk or posedge i_rst)
		if (i_rst)
			{d, t, r, o_ticks, o_rows} <= '0;
		else
		begin
			d <= i_sck;
			t <= i_row ? 16'h0000 : t + u;
			r <= i_frm ? 16'h0000 : r + {15'h0000, i_row};
			if (i_row)
				o_ticks <= t + u;
			if (i_frm)
				o_rows <= r + {15'h0000, i_row};
		end
endmodule

// ---- test/test_lss_scan_timing.sv ----
module test_lss_scan_timing;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_driver_width_pin = 1'b0;
	logic [7:0] o_rdata, o_row_line, o_scroll_row;
	logic o_shift_clock, o_row_start, o_frame_start, o_blink_phase, o_scroll_step, o_font_select;
	logic [3:0] o_ram_addr_hi, o_font_glyph;
	logic [15:0] m_ticks, m_rows, g;
	int n_errors = 0;
	int total_checks = 0;
	always #5 i_ref_clk = ~i_ref_clk;
	lss_scan_timing dut (.i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_driver_width_pin, .o_shift_clock, .o_row_start, .o_row_line, .o_frame_start,
		.o_blink_phase, .o_scroll_step, .o_scroll_row, .o_ram_addr_hi, .o_font_glyph,
		.o_font_select);
	lss_panel_model u_panel (.i_ref_clk, .i_rst, .i_sck(o_shift_clock), .i_row(o_row_start),
		.i_frm(o_frame_start), .o_ticks(m_ticks), .o_rows(m_rows));
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, exp);
	endtask
	// Skips one partial and one whole interval, then times the next one
	task automatic gap(input int sel, output logic [15:0] n);
		int seen;
		logic pb;
		n = 16'h0000;
		seen = 0;
		pb = o_blink_phase;
		for (int k = 0; k < 3000 && seen < 3; k++)
		begin
			@(posedge i_ref_clk);
			#1;
			if (seen == 2)
				n = n + 16'h0001;
			if (sel == 0 ? o_row_start === 1'b1 : sel == 1 ? o_frame_start === 1'b1 : o_blink_phase !== pb)
				seen++;
			pb = o_blink_phase;
		end
		if (seen < 3)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: no event", $time);
			final_report;
		end
	endtask
	task automatic t_regs;
		logic [7:0] a [6] = '{8'h70, 8'h71, 8'h72, 8'h80, 8'h90, 8'h55};
		foreach (a[k]) rdchk(a[k], 8'h00);
		wr(8'h71, 8'h12);
		rdchk(8'h71, 8'h12);
		wr(8'h72, 8'hEF);
		rdchk(8'h72, 8'hEF);
		$display("test regs done");
	endtask
	task automatic t_cursor;
		wr(8'h12, 8'h00);
		wr(8'h70, 8'hF5);
		rdchk(8'h70, 8'hEF);
		chk(o_ram_addr_hi, 16'h000F);
		wr(8'h70, 8'h3A);
		rdchk(8'h70, 8'h3A);
		chk({o_ram_addr_hi, o_font_glyph, 7'h00, o_font_select}, 16'hAA01);
		wr(8'h12, 8'h71);
		chk(o_font_select, 16'h0000);
		$display("test cursor done");
	endtask
	task automatic t_row;
		logic [7:0] md [4] = '{8'h70, 8'h60, 8'h50, 8'h00};
		logic [15:0] ex [4] = '{16'h000C, 16'h000C, 16'h0008, 16'h0008};
		logic [7:0] sc [3] = '{8'h00, 8'h04, 8'h08};
		logic [15:0] ey [3] = '{16'h0018, 16'h000C, 16'h0006};
		// Tiny window keeps frames short
		wr(8'h21, 8'h00);
		wr(8'h31, 8'h01);
		wr(8'h90, 8'h02);
		wr(8'h01, 8'h08);
		foreach (md[k])
		begin
			wr(8'h12, md[k]);
			gap(0, g);
			chk(g, ex[k]);
			chk(m_ticks, ex[k] >> 1);
		end
		@(posedge i_ref_clk);
		i_driver_width_pin <= 1'b1;
		foreach (sc[k])
		begin
			wr(8'h01, sc[k]);
			gap(0, g);
			chk(g, ey[k]);
			chk(m_ticks, 16'h0003);
		end
		// Divide by one: rows still timed, shift clock held low
		wr(8'h01, 8'h0C);
		gap(0, g);
		chk(g, 16'h0003);
		chk(m_ticks, 16'h0000);
		wr(8'h01, 8'h08);
		gap(1, g);
		chk(g, 16'h000C);
		chk(m_rows, 16'h0002);
		chk({8'h00, o_row_line}, 16'h0000);
		$display("test row done");
	endtask
	task automatic t_blink;
		logic [7:0] r1;
		wr(8'h71, 8'h10);
		wr(8'h72, 8'h11);
		wr(8'h13, 8'h01);
		wr(8'h80, 8'h00);
		gap(2, g);
		chk(g, 16'h000C);
		wr(8'h80, 8'h03);
		gap(2, g);
		chk(g, 16'h0024);
		chk(o_scroll_row >= 8'h10 && o_scroll_row <= 8'h11, 16'h0001);
		// Three steps between top and bottom flip the row
		r1 = o_scroll_row;
		gap(2, g);
		chk(g, 16'h0024);
		chk({8'h00, o_scroll_row}, {8'h00, 7'h08, ~r1[0]});
		rdchk(8'h14, {7'h01, o_blink_phase});
		$display("test blink done");
	endtask
	initial
	begin
		repeat (5) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		@(posedge i_ref_clk);
		t_regs();
		t_cursor();
		t_row();
		t_blink();
		final_report();
	end
endmodule
bind lss_scan_timing lss_scan_timing_chk u_chk (.i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
	.i_rd, .o_rdata, .o_row_start, .o_frame_start, .o_blink_phase, .o_scroll_step,
	.o_ram_addr_hi, .o_font_glyph, .o_row_line, .o_font_select);
